//--- common/adfc_pkg.sv
// Purpose: shared constants of the adc decimation filter control block
// Assumes: 125 MHz system clock, modulator ticks arrive as one-cycle strobes
// Notes: byte addresses are the full 32-bit apb addresses
`default_nettype none
package adfc_pkg;
  // register map
  localparam logic [31:0] ADFC_FILTER_CTRL_ADDR = 32'hffff0518;
  localparam logic [31:0] ADFC_EXT_CFG_ADDR = 32'hffff051c;
  localparam logic [31:0] ADFC_STATUS_ADDR = 32'hffff0520;
  localparam logic [15:0] ADFC_FILTER_CTRL_RESET = 16'h0007;
  localparam logic [7:0] ADFC_EXT_CFG_RESET = 8'h00;
  // filter control fields
  localparam int ADFC_CHOP_BIT = 15;
  localparam int ADFC_RAVG_BIT = 14;
  localparam int ADFC_AF_MSB = 13;
  localparam int ADFC_AF_LSB = 8;
  localparam int ADFC_NOTCH_BIT = 7;
  localparam int ADFC_SF_MSB = 6;
  // status fields
  localparam int ADFC_ST_SETTLED_BIT = 0;
  localparam int ADFC_ST_STARTUP_BIT = 1;
  localparam int ADFC_ST_LOWPWR_BIT = 2;
  localparam int ADFC_ST_RAVG_BIT = 3;
  localparam int ADFC_ST_STALL_BIT = 4;
  // rate arithmetic, in modulator ticks
  localparam int ADFC_STEP_SHIFT = 6;
  localparam int ADFC_PERIOD_W = 20;
  localparam int ADFC_AVG_BASE = 3;
  localparam int ADFC_MOD_FREQ_HZ = 512000;
  localparam logic [6:0] ADFC_SF_60HZ = 7'h7e;
  localparam logic [6:0] ADFC_SF_50HZ = 7'h7f;
  localparam int ADFC_RATE60_HZ = 60;
  localparam int ADFC_RATE50_HZ = 50;
  localparam logic [19:0] ADFC_TICKS_60HZ = 20'(ADFC_MOD_FREQ_HZ / ADFC_RATE60_HZ);
  localparam logic [19:0] ADFC_TICKS_50HZ = 20'(ADFC_MOD_FREQ_HZ / ADFC_RATE50_HZ);
  // settling, in output periods
  localparam logic [2:0] ADFC_SETTLE_PLAIN = 3'h3;
  localparam logic [2:0] ADFC_SETTLE_PLAIN_RAVG = 3'h4;
  localparam logic [2:0] ADFC_SETTLE_AVG = 3'h1;
  localparam logic [2:0] ADFC_SETTLE_AVG_RAVG = 3'h2;
  localparam logic [2:0] ADFC_SETTLE_CHOP = 3'h2;
  // first-result delay per enabled converter
  localparam int ADFC_CLK_PERIOD_NS = 8;
  localparam int ADFC_STARTUP_US = 60;
  localparam int ADFC_STARTUP_CYCLES =
      (ADFC_STARTUP_US * 1000 + ADFC_CLK_PERIOD_NS - 1) / ADFC_CLK_PERIOD_NS;
  localparam int ADFC_SU_W = 24;
endpackage : adfc_pkg
`default_nettype wire

//--- design/adfc_filter_ctrl.sv
// Purpose: apb-controlled sequencing of the sinc3 decimation filter
// Assumes: i_mod_tick and i_lp_tick are same-clock one-cycle strobes
// Notes: results pass a two-entry buffer; a full buffer holds the period count
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module adfc_filter_ctrl #(
  parameter int DATA_W = 16,
  parameter int STARTUP_CYCLES = adfc_pkg::ADFC_STARTUP_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_mod_tick,
  input wire logic i_lp_tick,
  input wire logic i_low_power_pin,
  input wire logic i_cur_en,
  input wire logic i_vt_en,
  input wire logic [DATA_W-1:0] i_sinc_data,
  output logic o_res_valid,
  output logic [DATA_W-1:0] o_res_data,
  input wire logic i_res_ready,
  output logic o_result_strobe,
  output logic o_cur_conv_rst,
  output logic o_vt_conv_rst,
  output logic o_chop_en,
  output logic o_second_notch,
  output logic [7:0] o_ext_config
);
  localparam int PW = adfc_pkg::ADFC_PERIOD_W;
  localparam int SUW = adfc_pkg::ADFC_SU_W;

  generate
    if (DATA_W < 2 || STARTUP_CYCLES < 1 || 2 * STARTUP_CYCLES >= 2 ** SUW) begin : g_bad
      $error("adfc_filter_ctrl: DATA_W or STARTUP_CYCLES out of range");
    end
  endgenerate

  typedef enum logic {ST_STARTUP, ST_RUN} adfc_state_t;

  // register group
  logic [15:0] ctrl_q, ctrl_d;
  logic [7:0] ext_q, ext_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic restart_q, restart_d;
  logic access, commit;
  // conversion group
  adfc_state_t state_q, state_d;
  logic [SUW-1:0] su_cnt_q, su_cnt_d;
  logic [PW-1:0] per_cnt_q, per_cnt_d;
  logic [2:0] settle_q, settle_d;
  logic [DATA_W-1:0] prev_q, prev_d, push_data_q, push_data_d;
  logic have_prev_q, have_prev_d, push_q, push_d, strobe_q, strobe_d;
  // derived
  logic chop, ravg_eff, lp_eff, tick, stall, buf_in_ready, settled;
  logic [5:0] af;
  logic [6:0] sf;
  logic [PW-1:0] period_len;
  logic [2:0] settle_target;
  logic [DATA_W:0] avg_sum;
  logic [SUW-1:0] su_load;

  function automatic logic [PW-1:0] adfc_period(input logic [6:0] f_sf,
                                                input logic [5:0] f_af,
                                                input logic f_chop);
    logic [13:0] base;
    logic [6:0] mult;
    logic [20:0] prod;
    base = 14'(f_sf + 7'h01) << adfc_pkg::ADFC_STEP_SHIFT;
    mult = 7'(f_af) + 7'(adfc_pkg::ADFC_AVG_BASE);
    prod = 21'(base) * 21'(mult);
    if (f_sf == adfc_pkg::ADFC_SF_60HZ) begin
      return adfc_pkg::ADFC_TICKS_60HZ;
    end else if (f_sf == adfc_pkg::ADFC_SF_50HZ) begin
      return adfc_pkg::ADFC_TICKS_50HZ;
    end else if (f_chop || f_af != 6'h00) begin
      return prod[PW-1:0];
    end else begin
      return PW'(base);
    end
  endfunction : adfc_period

  adfc_sync3 u_lp_sync (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_async(i_low_power_pin),
    .o_level(lp_eff)
  );

  always_comb begin
    chop = ctrl_q[adfc_pkg::ADFC_CHOP_BIT];
    af = ctrl_q[adfc_pkg::ADFC_AF_MSB:adfc_pkg::ADFC_AF_LSB];
    sf = ctrl_q[adfc_pkg::ADFC_SF_MSB:0];
    ravg_eff = ctrl_q[adfc_pkg::ADFC_RAVG_BIT] || chop;
    // slow oscillator in low power scales every rate by the tick source
    tick = lp_eff ? i_lp_tick : i_mod_tick;
    period_len = adfc_period(sf, af, chop);
    if (chop) begin
      settle_target = adfc_pkg::ADFC_SETTLE_CHOP;
    end else if (af != 6'h00) begin
      settle_target = ravg_eff ? adfc_pkg::ADFC_SETTLE_AVG_RAVG : adfc_pkg::ADFC_SETTLE_AVG;
    end else begin
      settle_target = ravg_eff ? adfc_pkg::ADFC_SETTLE_PLAIN_RAVG : adfc_pkg::ADFC_SETTLE_PLAIN;
    end
    settled = settle_q >= settle_target;
    stall = push_q && !buf_in_ready;
    avg_sum = {prev_q[DATA_W-1], prev_q} + {i_sinc_data[DATA_W-1], i_sinc_data};
    su_load = SUW'(STARTUP_CYCLES) * SUW'({1'b0, i_cur_en} + {1'b0, i_vt_en});
  end

  // apb slave: pready one cycle into access, write lands on that edge
  always_comb begin
    access = i_psel && i_penable;
    commit = access && pready_q;
    pready_d = access && !pready_q;
    prdata_d = 32'h0000_0000;
    pslverr_d = 1'b0;
    ctrl_d = ctrl_q;
    ext_d = ext_q;
    restart_d = 1'b0;
    if (pready_d) begin
      if (i_paddr == adfc_pkg::ADFC_FILTER_CTRL_ADDR) begin
        prdata_d = {16'h0000, ctrl_q};
      end else if (i_paddr == adfc_pkg::ADFC_EXT_CFG_ADDR) begin
        prdata_d = {24'h00_0000, ext_q};
      end else if (i_paddr == adfc_pkg::ADFC_STATUS_ADDR) begin
        prdata_d[adfc_pkg::ADFC_ST_SETTLED_BIT] = settled;
        prdata_d[adfc_pkg::ADFC_ST_STARTUP_BIT] = state_q == ST_STARTUP;
        prdata_d[adfc_pkg::ADFC_ST_LOWPWR_BIT] = lp_eff;
        prdata_d[adfc_pkg::ADFC_ST_RAVG_BIT] = ravg_eff;
        prdata_d[adfc_pkg::ADFC_ST_STALL_BIT] = stall;
      end else begin
        pslverr_d = 1'b1;
      end
    end
    if (commit && i_pwrite) begin
      if (i_paddr == adfc_pkg::ADFC_FILTER_CTRL_ADDR) begin
        ctrl_d = i_pwdata[15:0];
        restart_d = i_pwdata[15:0] != ctrl_q;
      end else if (i_paddr == adfc_pkg::ADFC_EXT_CFG_ADDR) begin
        ext_d = i_pwdata[7:0];
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      ctrl_q <= adfc_pkg::ADFC_FILTER_CTRL_RESET;
      ext_q <= adfc_pkg::ADFC_EXT_CFG_RESET;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      restart_q <= 1'b1;
    end else if (i_ce) begin
      ctrl_q <= ctrl_d;
      ext_q <= ext_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      restart_q <= restart_d;
    end
  end

  // conversion sequencing; a full buffer holds the counter, no word is lost
  always_comb begin
    state_d = state_q;
    su_cnt_d = su_cnt_q;
    per_cnt_d = per_cnt_q;
    settle_d = settle_q;
    prev_d = prev_q;
    have_prev_d = have_prev_q;
    push_d = stall;
    push_data_d = push_data_q;
    strobe_d = 1'b0;
    if (restart_q) begin
      state_d = ST_STARTUP;
      su_cnt_d = su_load;
      per_cnt_d = '0;
      settle_d = 3'h0;
      have_prev_d = 1'b0;
    end else begin
      case (state_q)
        ST_STARTUP: begin
          if (su_cnt_q == '0) begin
            state_d = ST_RUN;
          end else begin
            su_cnt_d = su_cnt_q - SUW'(1);
          end
        end
        ST_RUN: begin
          if (tick && !stall) begin
            if (per_cnt_q >= period_len - PW'(1)) begin
              per_cnt_d = '0;
              prev_d = i_sinc_data;
              have_prev_d = 1'b1;
              if (!settled) begin
                settle_d = settle_q + 3'h1;
              end
              if (settle_q + 3'h1 >= settle_target) begin
                push_d = 1'b1;
                strobe_d = 1'b1;
                push_data_d = (ravg_eff && have_prev_q) ? avg_sum[DATA_W:1] : i_sinc_data;
              end
            end else begin
              per_cnt_d = per_cnt_q + PW'(1);
            end
          end
        end
        default: state_d = ST_STARTUP;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_q <= ST_STARTUP;
      su_cnt_q <= '0;
      per_cnt_q <= '0;
      settle_q <= 3'h0;
      prev_q <= '0;
      have_prev_q <= 1'b0;
      push_q <= 1'b0;
      push_data_q <= '0;
      strobe_q <= 1'b0;
    end else if (i_ce) begin
      state_q <= state_d;
      su_cnt_q <= su_cnt_d;
      per_cnt_q <= per_cnt_d;
      settle_q <= settle_d;
      prev_q <= prev_d;
      have_prev_q <= have_prev_d;
      push_q <= push_d;
      push_data_q <= push_data_d;
      strobe_q <= strobe_d;
    end
  end

  adfc_skid_buf #(.W(DATA_W)) u_res_buf (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_in_valid(push_q),
    .i_in_data(push_data_q),
    .o_in_ready(buf_in_ready),
    .o_out_valid(o_res_valid),
    .o_out_data(o_res_data),
    .i_out_ready(i_res_ready)
  );

  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_result_strobe = strobe_q;
  assign o_cur_conv_rst = restart_q;
  assign o_vt_conv_rst = restart_q;
  assign o_chop_en = ctrl_q[adfc_pkg::ADFC_CHOP_BIT];
  assign o_second_notch = ctrl_q[adfc_pkg::ADFC_NOTCH_BIT];
  assign o_ext_config = ext_q;

  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  ctrl_write_reset_a: assert property (
    i_ce && commit && i_pwrite && i_paddr == adfc_pkg::ADFC_FILTER_CTRL_ADDR
    && i_pwdata[15:0] != ctrl_q |=> o_cur_conv_rst && o_vt_conv_rst)
    else $error("filter control change did not reset converters");
  chop_third_rate_a: assert property (
    chop && af == 6'h00 && sf <= 7'd125 |-> int'(period_len) ==
    ((int'(sf) + 1) << adfc_pkg::ADFC_STEP_SHIFT) * adfc_pkg::ADFC_AVG_BASE)
    else $error("chopped rate is not a third");
  avg_rate_same_a: assert property (
    af != 6'h00 && sf <= 7'd125 |-> int'(period_len) == int'(adfc_period(sf, af, 1'b0))
    && int'(period_len) == int'(adfc_period(sf, af, 1'b1)))
    else $error("averaged rate depends on chop");
  avg_factor_rate_a: assert property (
    af != 6'h00 && sf <= 7'd125 |-> int'(period_len) ==
    ((int'(sf) + 1) << adfc_pkg::ADFC_STEP_SHIFT) * (adfc_pkg::ADFC_AVG_BASE + int'(af)))
    else $error("averaging factor rate wrong");
  ravg_forced_a: assert property (
    o_chop_en |-> ravg_eff && settle_target == adfc_pkg::ADFC_SETTLE_CHOP)
    else $error("running average not forced by chop");
  notch_follow_a: assert property (
    i_ce && commit && i_pwrite && i_paddr == adfc_pkg::ADFC_FILTER_CTRL_ADDR
    |=> o_second_notch == $past(i_pwdata[adfc_pkg::ADFC_NOTCH_BIT]))
    else $error("second notch does not follow write");
  plain_rate_a: assert property (
    !chop && af == 6'h00 && sf <= 7'd125 |->
    int'(period_len) == ((int'(sf) + 1) << adfc_pkg::ADFC_STEP_SHIFT))
    else $error("plain rate wrong");
  forced_rate_a: assert property (
    sf == adfc_pkg::ADFC_SF_60HZ |-> period_len == adfc_pkg::ADFC_TICKS_60HZ)
    else $error("factor 126 not forced to 60 Hz");
  lp_source_a: assert property (
    state_q == ST_RUN && !restart_q && !stall && i_ce && lp_eff && !i_lp_tick
    |=> $stable(per_cnt_q))
    else $error("low power counts on the wrong tick");
  settle_hold_a: assert property (
    o_result_strobe |-> $past(settle_q, 1) + 3'h1 >= $past(settle_target, 1))
    else $error("result strobed before settling");
  startup_quiet_a: assert property (
    state_q == ST_STARTUP |=> !o_result_strobe)
    else $error("result during startup delay");
  strobe_single_a: assert property (
    o_result_strobe |=> !o_result_strobe)
    else $error("result strobe wider than one cycle");

  result_chop_c: cover property (o_result_strobe && o_chop_en);
  result_avg_c: cover property (o_result_strobe && af != 6'h00);
  buffer_stall_c: cover property (stall ##1 stall);
  bad_addr_c: cover property (o_pready && o_pslverr);
endmodule : adfc_filter_ctrl
`default_nettype wire

//--- design/adfc_skid_buf.sv
// Purpose: two-entry result buffer with valid and ready on both sides
// Assumes: single clock, all outputs registered
// Notes: ready on the fill side drops only while the spare slot is taken
`timescale 1ns/1ps
`default_nettype none
module adfc_skid_buf #(
  parameter int W = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_in_valid,
  input wire logic [W-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [W-1:0] o_out_data,
  input wire logic i_out_ready
);
  logic out_v_q, out_v_d, sp_v_q, sp_v_d;
  logic [W-1:0] out_d_q, out_d_d, sp_d_q, sp_d_d;

  generate
    if (W < 1) begin : g_bad_w
      $error("adfc_skid_buf: W must be at least 1");
    end
  endgenerate

  always_comb begin
    out_v_d = out_v_q;
    out_d_d = out_d_q;
    sp_v_d = sp_v_q;
    sp_d_d = sp_d_q;
    if (out_v_q && i_out_ready) begin
      out_v_d = sp_v_q;
      out_d_d = sp_d_q;
      sp_v_d = 1'b0;
    end
    if (i_in_valid && !sp_v_q) begin
      if (!out_v_d) begin
        out_v_d = 1'b1;
        out_d_d = i_in_data;
      end else begin
        sp_v_d = 1'b1;
        sp_d_d = i_in_data;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      out_v_q <= 1'b0;
      sp_v_q <= 1'b0;
      out_d_q <= '0;
      sp_d_q <= '0;
    end else if (i_ce) begin
      out_v_q <= out_v_d;
      sp_v_q <= sp_v_d;
      out_d_q <= out_d_d;
      sp_d_q <= sp_d_d;
    end
  end

  assign o_in_ready = !sp_v_q;
  assign o_out_valid = out_v_q;
  assign o_out_data = out_d_q;
endmodule : adfc_skid_buf
`default_nettype wire

//--- design/adfc_sync3.sv
// Purpose: three-stage synchroniser for a pin level
// Assumes: input is asynchronous to i_sys_clk
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module adfc_sync3 (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_async,
  output logic o_level
);
  logic s1_q, s2_q, s3_q, lvl_q;
  logic s1_d, s2_d, s3_d, lvl_d;

  always_comb begin
    s1_d = i_async;
    s2_d = s1_q;
    s3_d = s2_q;
    lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
    end else if (i_ce) begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      lvl_q <= lvl_d;
    end
  end

  assign o_level = lvl_q;
endmodule : adfc_sync3
`default_nettype wire

//--- verif/adfc_filter_ctrl_bench.sv
// Purpose: self-checking bench of the filter control block over apb
// Assumes: startup shortened to 4 cycles per converter, both converters on
// Notes: rates are measured in ticks of whichever source is selected
`timescale 1ns/1ps
`default_nettype none
module adfc_filter_ctrl_bench;
  localparam logic [31:0] A_CTRL = adfc_pkg::ADFC_FILTER_CTRL_ADDR;
  localparam logic [31:0] A_EXT = adfc_pkg::ADFC_EXT_CFG_ADDR;
  localparam int SU = 4;
  logic clk, rst, psel, pen, pwr, pready, pslverr, mtick, ltick, lpin;
  logic rvalid, rready, strobe, crst, vrst, chop, notch, tk;
  logic [31:0] paddr, pwdata, prdata, r;
  logic [15:0] sdata, rdata, sd_q;
  logic [7:0] ext;
  logic e;
  int error_cnt, num_checks, nrst, nstb, nacc, waits, n, n0;
  assign tk = lpin ? ltick : mtick;
  adfc_mod_model #(.LP_GAP(4)) model (.i_sys_clk(clk), .i_reset(rst), .o_mod_tick(mtick),
    .o_lp_tick(ltick), .o_sinc_data(sdata));
  adfc_filter_ctrl #(.DATA_W(16), .STARTUP_CYCLES(SU)) dut (.i_sys_clk(clk), .i_reset(rst),
    .i_ce(1'b1), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_mod_tick(mtick), .i_lp_tick(ltick), .i_low_power_pin(lpin), .i_cur_en(1'b1),
    .i_vt_en(1'b1), .i_sinc_data(sdata), .o_res_valid(rvalid), .o_res_data(rdata),
    .i_res_ready(rready), .o_result_strobe(strobe), .o_cur_conv_rst(crst), .o_vt_conv_rst(vrst),
    .o_chop_en(chop), .o_second_notch(notch), .o_ext_config(ext));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    // sample that the filter took at the previous edge
    sd_q <= sdata;
    if (crst === 1'b1 && vrst === 1'b1) nrst <= nrst + 1;
    if (strobe === 1'b1) nstb <= nstb + 1;
    if (rvalid === 1'b1 && rready === 1'b1) nacc <= nacc + 1;
  end
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one transfer; the request holds until pready is sampled high
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    waits = 0;
    do begin
      @(posedge clk);
      waits++;
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    // one idle edge, so a following call never re-drives psel in this step
    @(posedge clk);
  endtask : apb
  task rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp, input logic ee);
    apb(1'b0, a, 32'h0);
    chk(what, r, exp);
    chk({what, " err"}, {31'h0, e}, {31'h0, ee});
  endtask : rd_chk
  // ticks up to and including the one that ends a result period
  task cnt;
    n = 0;
    do begin
      if (tk === 1'b1) n++;
      @(posedge clk);
    end while (strobe !== 1'b1);
  endtask : cnt
  task meas(input string what, input logic [15:0] v, input int per, input int st, input bit two);
    int lo;
    logic [15:0] s1, ex;
    logic [16:0] sm;
    apb(1'b1, A_CTRL, {16'h0, v});
    lo = per * st + (lpin ? 1 : 2 * SU);
    cnt();
    s1 = sd_q;
    chk({what, " first"}, {31'h0, n >= lo && n <= lo + 24}, 32'h1);
    if (two) begin
      cnt();
      chk({what, " period"}, 32'(n), 32'(per));
      // running average: signed mean of the last two raw samples
      sm = {s1[15], s1} + {sd_q[15], sd_q};
      ex = (v[15] || v[14]) ? sm[16:1] : sd_q;
      @(posedge clk);
      chk({what, " data"}, {15'h0, rvalid, rdata}, {15'h0, 1'b1, ex});
    end
    $display("test %s done", what);
  endtask : meas
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (95000) @(posedge clk);
    error_cnt++;
    summarize();
  end
  initial begin
    rst = 1'b1;
    {psel, pen, pwr, lpin} = 4'h0;
    rready = 1'b1;
    paddr = 32'h0;
    pwdata = 32'h0;
    {error_cnt, num_checks, nrst, nstb, nacc} = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk("ctrl reset", A_CTRL, 32'h0007, 1'b0);
    chk("apb waits", 32'(waits), 32'h2);
    rd_chk("ext reset", A_EXT, 32'h0, 1'b0);
    rd_chk("unmapped", 32'hffff0600, 32'h0, 1'b1);
    apb(1'b1, A_EXT, 32'hffffffa5);
    chk("ext pin", {24'h0, ext}, 32'ha5);
    rd_chk("ext back", A_EXT, 32'ha5, 1'b0);
    $display("test registers done");
    // rewriting the same value must not restart, a new value must
    n0 = nrst;
    apb(1'b1, A_CTRL, 32'h0007);
    repeat (3) @(posedge clk);
    chk("same value restart", 32'(nrst - n0), 32'h0);
    apb(1'b1, A_CTRL, 32'hffff0003);
    repeat (3) @(posedge clk);
    chk("change restart", 32'(nrst - n0), 32'h1);
    rd_chk("status startup", adfc_pkg::ADFC_STATUS_ADDR, 32'h2, 1'b0);
    rd_chk("ctrl back", A_CTRL, 32'h0003, 1'b0);
    // each setting: first-result delay after its settling periods, then period and data where two is set
    meas("plain", 16'h0000, 64, 3, 1);
    meas("ravg", 16'h4000, 64, 4, 1);
    meas("af", 16'h0201, 640, 1, 1);
    meas("af ravg", 16'h4201, 640, 2, 1);
    meas("af max", 16'h3f00, 4224, 1, 1);
    meas("chop", 16'h8000, 192, 2, 1);
    chk("chop pin", {31'h0, chop}, 32'h1);
    meas("chop af", 16'h8201, 640, 2, 1);
    meas("notch", 16'h0083, 256, 3, 1);
    chk("notch pin", {30'h0, notch, chop}, 32'h2);
    meas("60hz", 16'h007e, 32'(adfc_pkg::ADFC_TICKS_60HZ), 3, 0);
    meas("50hz", 16'h007f, 32'(adfc_pkg::ADFC_TICKS_50HZ), 3, 0);
    // a stalled sink fills both slots, then the period count holds
    meas("stall", 16'h0000, 64, 3, 0);
    rready <= 1'b0;
    // skip the edge that counts the result just seen
    @(posedge clk);
    n0 = nstb;
    repeat (640) @(posedge clk);
    chk("stalled results", 32'(nstb - n0), 32'h2);
    chk("held valid", {31'h0, rvalid}, 32'h1);
    rready <= 1'b1;
    cnt();
    repeat (4) @(posedge clk);
    chk("no word lost", 32'(nacc), 32'(nstb));
    // slow source selected; the switch alone does not restart
    lpin <= 1'b1;
    repeat (8) @(posedge clk);
    meas("low power", 16'h0001, 128, 3, 1);
    lpin <= 1'b0;
    summarize();
  end
endmodule : adfc_filter_ctrl_bench
`default_nettype wire

//--- verif/adfc_mod_model.sv
// Purpose: stand-in for the modulator tick sources and the sinc3 result word
// Assumes: ticks are same-clock strobes; the modulator ticks every cycle
// Notes: the low power tick is slow on purpose; data moves every cycle so a stale sample shows
`timescale 1ns/1ps
`default_nettype none
module adfc_mod_model #(
  parameter int LP_GAP = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  output logic o_mod_tick,
  output logic o_lp_tick,
  output logic [15:0] o_sinc_data
);
  int lp_cnt;
  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      lp_cnt <= 0;
      o_mod_tick <= 1'b0;
      o_lp_tick <= 1'b0;
      o_sinc_data <= 16'h0000;
    end else begin
      // fast clock source, about four times the low power one
      o_mod_tick <= 1'b1;
      lp_cnt <= (lp_cnt == LP_GAP - 1) ? 0 : lp_cnt + 1;
      o_lp_tick <= (lp_cnt == LP_GAP - 1);
      o_sinc_data <= o_sinc_data + 16'h0101;
    end
  end
endmodule : adfc_mod_model
`default_nettype wire
